// file: alcr_cfg.svh
// Constants of the frequency control loop configuration slice.
// Assumes inclusion by bare name; holds definitions only.
`ifndef ALCR_CFG_SVH
`define ALCR_CFG_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte address = 4 x index)
// ----------------------------------------------------------------
`define ALCR_IDX_MODE_CONFIG      12'h116
`define ALCR_IDX_LOOP_GAINS       12'h117
`define ALCR_IDX_PHASE_TRIM       12'h118
`define ALCR_IDX_LOOP_STATUS      12'h11D
`define ALCR_IDX_LOOP_CORRECTION  12'h11E
`define ALCR_ADDR_W               14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ALCR_MODE_LSB             0
`define ALCR_MODE_MSB             1
`define ALCR_SCHEME_LSB           2
`define ALCR_SCHEME_MSB           3
`define ALCR_POLARITY_BIT         4
`define ALCR_KI_LSB               0
`define ALCR_KI_MSB               3
`define ALCR_KP_LSB               4
`define ALCR_KP_MSB               7
`define ALCR_PHASE_LSB            0
`define ALCR_PHASE_MSB            6
`define ALCR_STAT_LOCKED_BIT      0
`define ALCR_STAT_RUNNING_BIT     1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ALCR_RST_MODE_CONFIG      8'h08
`define ALCR_RST_LOOP_GAINS       8'h37
`define ALCR_RST_PHASE_TRIM       8'h00

`endif

// file: alcr_pkg.sv
// Types shared by the frequency control loop configuration slice.
// Assumes nothing beyond a SystemVerilog compiler.
package alcr_pkg;

    // Loop mode codes as held in the mode field
    typedef enum logic [1:0] {
        ALCR_MODE_FREE = 2'h0,
        ALCR_MODE_OFF  = 2'h1,
        ALCR_MODE_HOLD = 2'h2,
        ALCR_MODE_LOCK = 2'h3
    } alcr_mode_t;

    // One-hot loop controller states
    typedef enum logic [3:0] {
        ALCR_ST_RUN    = 4'h1,
        ALCR_ST_OFF    = 4'h2,
        ALCR_ST_HOLD   = 4'h4,
        ALCR_ST_LOCKED = 4'h8
    } alcr_state_t;

endpackage

// file: alcr_pi_loop.sv
// PI frequency correction loop steered by the mode and gain fields.
// Assumes error samples and the sync flag come from logic on pclk.
`timescale 1ns/100ps
`default_nettype none

module alcr_pi_loop
    import alcr_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Configuration
    input  wire logic [1:0]  loop_mode,
    input  wire logic [3:0]  prop_gain,
    input  wire logic [3:0]  integ_gain,
    // Demodulator side
    input  wire logic        err_valid,
    input  wire logic [15:0] freq_err,
    input  wire logic        sync_found,
    input  wire logic        rx_restart,
    // Results
    output logic [31:0]      correction,
    output logic             locked,
    output logic             running
);

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    alcr_state_t        state;
    alcr_state_t        next_state;
    logic signed [31:0] integ;
    logic signed [31:0] err_ext;
    logic signed [31:0] next_integ;
    logic signed [31:0] next_corr;

    // Next state from the mode field
    always_comb begin
        next_state = ALCR_ST_RUN;
        unique case (alcr_mode_t'(loop_mode))
            ALCR_MODE_FREE: next_state = ALCR_ST_RUN;
            ALCR_MODE_OFF:  next_state = ALCR_ST_OFF;
            ALCR_MODE_HOLD: next_state = ALCR_ST_HOLD;
            ALCR_MODE_LOCK: begin
                // Lock stays until the receiver restarts a search
                if (state == ALCR_ST_LOCKED && !rx_restart) begin
                    next_state = ALCR_ST_LOCKED;
                end else if (sync_found && !rx_restart) begin
                    next_state = ALCR_ST_LOCKED;
                end else begin
                    next_state = ALCR_ST_RUN;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ALCR_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // PI arithmetic
    // ------------------------------------------------------------
    // Shift of 15 on a 16-bit error fits 31 bits; the integrator wraps
    always_comb begin
        err_ext    = 32'(signed'(freq_err));
        next_integ = integ + (err_ext <<< integ_gain);
        next_corr  = next_integ + (err_ext <<< prop_gain);
    end

    // Integrator and correction; off clears, hold and lock freeze
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            integ      <= 32'h0000_0000;
            correction <= 32'h0000_0000;
        end else if (state == ALCR_ST_OFF) begin
            integ      <= 32'h0000_0000;
            correction <= 32'h0000_0000;
        end else if (state == ALCR_ST_RUN && err_valid) begin
            integ      <= next_integ;
            correction <= next_corr;
        end
    end

    // Status flags as flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked  <= 1'b0;
            running <= 1'b0;
        end else begin
            locked  <= (next_state == ALCR_ST_LOCKED);
            running <= (next_state == ALCR_ST_RUN);
        end
    end

endmodule

`default_nettype wire

// file: alcr_top.sv
// APB register slice for the frequency control loop, with its loop.
// Assumes an APB master on pclk and demodulator inputs on pclk too.
`timescale 1ns/100ps
`default_nettype none
`include "alcr_cfg.svh"

module alcr_top
    import alcr_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Demodulator side
    input  wire logic        err_valid,
    input  wire logic [15:0] freq_err,
    input  wire logic        sync_found,
    input  wire logic        rx_restart,
    // Receiver controls
    output logic [31:0]      freq_correction,
    output logic             freq_loop_locked,
    output logic             freq_loop_running,
    output logic [6:0]       iq_phase_trim,
    output logic             freq_loop_polarity,
    output logic [1:0]       freq_loop_scheme
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]  afc_mode_config;
    logic [7:0]  afc_loop_gains;
    logic [7:0]  image_reject_phase_trim;
    logic [1:0]  freq_loop_mode;
    logic [3:0]  freq_loop_prop_gain;
    logic [3:0]  freq_loop_integ_gain;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic        setup;
    logic        commit;
    logic        hit_mode;
    logic        hit_gains;
    logic        hit_phase;
    logic        hit_status;
    logic        hit_corr;
    logic        mapped;
    logic [31:0] next_rdata;

    // Index decode; low two address bits must be zero
    always_comb begin
        hit_mode   = (paddr == 32'(`ALCR_IDX_MODE_CONFIG) << 2);
        hit_gains  = (paddr == 32'(`ALCR_IDX_LOOP_GAINS) << 2);
        hit_phase  = (paddr == 32'(`ALCR_IDX_PHASE_TRIM) << 2);
        hit_status = (paddr == 32'(`ALCR_IDX_LOOP_STATUS) << 2);
        hit_corr   = (paddr == 32'(`ALCR_IDX_LOOP_CORRECTION) << 2);
        mapped     = hit_mode | hit_gains | hit_phase | hit_status | hit_corr;
    end

    // Setup phase prepares the answer; the access edge commits it
    assign setup  = psel & ~penable;
    assign commit = psel & penable & pready;

    // Read mux; narrow registers sit in the low byte
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_mode) begin
            next_rdata = {24'h00_0000, afc_mode_config};
        end else if (hit_gains) begin
            next_rdata = {24'h00_0000, afc_loop_gains};
        end else if (hit_phase) begin
            next_rdata = {24'h00_0000, image_reject_phase_trim};
        end else if (hit_status) begin
            next_rdata = {30'h0000_0000, freq_loop_running, freq_loop_locked};
        end else if (hit_corr) begin
            next_rdata = freq_correction;
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // One registered answer cycle keeps every bus output on a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // All eight bits are stored as written; software owns reserved bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afc_mode_config <= `ALCR_RST_MODE_CONFIG;
        end else if (commit && pwrite && hit_mode) begin
            afc_mode_config <= pwdata[7:0];
        end
    end

    // Gains register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afc_loop_gains <= `ALCR_RST_LOOP_GAINS;
        end else if (commit && pwrite && hit_gains) begin
            afc_loop_gains <= pwdata[7:0];
        end
    end

    // Phase trim register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            image_reject_phase_trim <= `ALCR_RST_PHASE_TRIM;
        end else if (commit && pwrite && hit_phase) begin
            image_reject_phase_trim <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    assign freq_loop_mode       = afc_mode_config[`ALCR_MODE_MSB:`ALCR_MODE_LSB];
    assign freq_loop_prop_gain  = afc_loop_gains[`ALCR_KP_MSB:`ALCR_KP_LSB];
    assign freq_loop_integ_gain = afc_loop_gains[`ALCR_KI_MSB:`ALCR_KI_LSB];

    // Scheme and polarity fields and trim leave through flops, one cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iq_phase_trim      <= 7'h00;
            freq_loop_polarity <= 1'b0;
            freq_loop_scheme   <= 2'h0;
        end else begin
            iq_phase_trim      <= image_reject_phase_trim[`ALCR_PHASE_MSB:`ALCR_PHASE_LSB];
            freq_loop_polarity <= afc_mode_config[`ALCR_POLARITY_BIT];
            freq_loop_scheme   <= afc_mode_config[`ALCR_SCHEME_MSB:`ALCR_SCHEME_LSB];
        end
    end

    // ------------------------------------------------------------
    // Loop controller
    // ------------------------------------------------------------
    alcr_pi_loop u_loop (
        .pclk       (pclk),
        .presetn    (presetn),
        .loop_mode  (freq_loop_mode),
        .prop_gain  (freq_loop_prop_gain),
        .integ_gain (freq_loop_integ_gain),
        .err_valid  (err_valid),
        .freq_err   (freq_err),
        .sync_found (sync_found),
        .rx_restart (rx_restart),
        .correction (freq_correction),
        .locked     (freq_loop_locked),
        .running    (freq_loop_running)
    );

endmodule

`default_nettype wire

// file: alcr_top_checker.sv
// Checker bound into alcr_top: APB answer and loop mode behaviour.
// Assumes one clock, pclk, and presetn as async active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "alcr_cfg.svh"
module alcr_top_checker (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Loop side
    input wire logic        sync_found,
    input wire logic        rx_restart,
    input wire logic [31:0] freq_correction,
    input wire logic        freq_loop_locked,
    input wire logic        freq_loop_running,
    input wire logic [6:0]  iq_phase_trim
);
    // ----
    // Decode
    // ----
    logic [1:0] mode_q;
    wire logic  acc = psel && penable && pready && pwrite && paddr[31:14] == 18'h0;
    wire logic  wr_mode = acc && paddr[13:0] == {`ALCR_IDX_MODE_CONFIG, 2'h0};
    wire logic  wr_phase = acc && paddr[13:0] == {`ALCR_IDX_PHASE_TRIM, 2'h0};
    wire logic  mapped = paddr[31:14] == 18'h0 && paddr[1:0] == 2'h0 &&
        paddr[13:2] inside {`ALCR_IDX_MODE_CONFIG, `ALCR_IDX_LOOP_GAINS,
        `ALCR_IDX_PHASE_TRIM, `ALCR_IDX_LOOP_STATUS, `ALCR_IDX_LOOP_CORRECTION};
    // Mode shadow; updated on the write edge so it matches the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
        end else if (wr_mode) begin
            mode_q <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_bad; psel && !penable && !mapped; endsequence
    sequence s_mode_wr(m); wr_mode && pwdata[1:0] == m; endsequence
    property p_ready; s_setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no zero-wait pready");
    property p_bad; s_bad |=> pready && pslverr; endproperty
    a_bad: assert property (p_bad) else $error("no slave error");
    property p_off; s_mode_wr(2'h1) |=> ##1 !freq_loop_running ##1 freq_correction == 0; endproperty
    a_off: assert property (p_off) else $error("loop not off");
    property p_hold; s_mode_wr(2'h2) |=> ##2 $stable(freq_correction) [*2]; endproperty
    a_hold: assert property (p_hold) else $error("hold moved");
    property p_lock;
        mode_q == 2'h3 && freq_loop_running && sync_found && !rx_restart |=> freq_loop_locked;
    endproperty
    a_lock: assert property (p_lock) else $error("no lock");
    property p_frozen; freq_loop_locked |=> $stable(freq_correction); endproperty
    a_frozen: assert property (p_frozen) else $error("lock moved");
    property p_release; freq_loop_locked && rx_restart |=> !freq_loop_locked; endproperty
    a_release: assert property (p_release) else $error("lock kept");
    property p_trim; wr_phase |=> ##1 iq_phase_trim == $past(pwdata[6:0], 2); endproperty
    a_trim: assert property (p_trim) else $error("trim wrong");
endmodule

bind alcr_top alcr_top_checker i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .sync_found(sync_found), .rx_restart(rx_restart), .freq_correction(freq_correction),
    .freq_loop_locked(freq_loop_locked), .freq_loop_running(freq_loop_running),
    .iq_phase_trim(iq_phase_trim)
);
`default_nettype wire

// file: afc_loop_config_regs_test.sv
// Self-checking bench for alcr_top: registers and loop modes.
// Assumes the design and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "alcr_cfg.svh"
module afc_loop_config_regs_test import alcr_pkg::*;;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, c0, freq_correction;
    logic        pready, pslverr, er, freq_loop_locked, freq_loop_running, freq_loop_polarity;
    logic        err_valid = 1'b0, sync_found = 1'b0, rx_restart = 1'b0;
    logic [15:0] freq_err = 16'h0;
    logic [6:0]  iq_phase_trim;
    logic [1:0]  freq_loop_scheme;
    int          fails = 0, n_compared = 0, cyc = 0;
    alcr_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .err_valid(err_valid), .freq_err(freq_err), .sync_found(sync_found),
        .rx_restart(rx_restart), .freq_correction(freq_correction),
        .freq_loop_locked(freq_loop_locked), .freq_loop_running(freq_loop_running),
        .iq_phase_trim(iq_phase_trim), .freq_loop_polarity(freq_loop_polarity),
        .freq_loop_scheme(freq_loop_scheme)
    );
    // ----
    // Clock, hang guard, helpers
    // ----
    initial begin
        forever #50 pclk = ~pclk;
    end
    // Run needs about 110 cycles; the ceiling leaves ample margin
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            final_report();
        end
    end
    task automatic final_report;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One APB transfer; waits on pready, the timeout cuts a hang
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {18'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        cmp(what, exp, rd);
    endtask
    task automatic set_mode(input logic [1:0] m);
        apb(1'b1, `ALCR_IDX_MODE_CONFIG, {28'h0, 2'h2, m});
        tick(3);
    endtask
    task automatic pulse_err(input logic [15:0] e);
        @(posedge pclk);
        err_valid <= 1'b1;
        freq_err <= e;
        @(posedge pclk);
        err_valid <= 1'b0;
        tick(3);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rd_chk("mode_config", `ALCR_IDX_MODE_CONFIG, 32'h08);
        rd_chk("loop_gains", `ALCR_IDX_LOOP_GAINS, 32'h37);
        rd_chk("phase_trim", `ALCR_IDX_PHASE_TRIM, 32'h00);
        rd_chk("status", `ALCR_IDX_LOOP_STATUS, 32'h02);
        cmp("scheme", 32'h2, {30'h0, freq_loop_scheme});
        cmp("polarity", 32'h0, {31'h0, freq_loop_polarity});
        $display("t_reset done");
    endtask
    task automatic t_regs;
        apb(1'b1, `ALCR_IDX_PHASE_TRIM, 32'h7F);
        tick(2);
        cmp("trim pins", 32'h7F, {25'h0, iq_phase_trim});
        apb(1'b1, `ALCR_IDX_PHASE_TRIM, 32'h2A);
        rd_chk("phase_trim", `ALCR_IDX_PHASE_TRIM, 32'h2A);
        rd_chk("unmapped", 12'h119, 32'h0);
        cmp("pslverr", 32'h1, {31'h0, er});
        $display("t_regs done");
    endtask
    // Cleared loop, one error sample: correction is both shifted terms.
    // A second sample doubles only the integral term, so swapped gains show.
    task automatic gain_case(input logic [3:0] kp, input logic [3:0] ki, input logic [15:0] e);
        logic [31:0] se;
        se = {{16{e[15]}}, e};
        set_mode(2'h1);
        cmp("off", 32'h0, {30'h0, freq_loop_running, freq_loop_locked});
        cmp("cleared", 32'h0, freq_correction);
        apb(1'b1, `ALCR_IDX_LOOP_GAINS, {24'h0, kp, ki});
        set_mode(2'h0);
        pulse_err(e);
        cmp("correction", (se << ki) + (se << kp), freq_correction);
        rd_chk("corr reg", `ALCR_IDX_LOOP_CORRECTION, (se << ki) + (se << kp));
        pulse_err(e);
        cmp("integrated", ((se << ki) << 1) + (se << kp), freq_correction);
        $display("gain_case done");
    endtask
    task automatic t_lock;
        set_mode(2'h3);
        cmp("running", 32'h1, {31'h0, freq_loop_running});
        @(posedge pclk);
        sync_found <= 1'b1;
        @(posedge pclk);
        sync_found <= 1'b0;
        tick(1);
        cmp("locked", 32'h1, {31'h0, freq_loop_locked});
        c0 = freq_correction;
        pulse_err(16'h0100);
        cmp("frozen", c0, freq_correction);
        @(posedge pclk);
        rx_restart <= 1'b1;
        @(posedge pclk);
        rx_restart <= 1'b0;
        tick(1);
        cmp("released", 32'h1, {31'h0, freq_loop_running});
        set_mode(2'h2);
        c0 = freq_correction;
        pulse_err(16'h0100);
        cmp("held", c0, freq_correction);
        $display("t_lock done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        gain_case(4'h3, 4'h7, 16'h0005);
        gain_case(4'hF, 4'h0, 16'hFFFD);
        t_lock();
        final_report();
    end
endmodule
`default_nettype wire
